//--- logic/opsmp_pkg.sv
// Package: constants, selectors and carriers for the op sampling unit.
package opsmp_pkg;
   // ==========================================================
   // Widths and counts
   localparam int CNT_W_NARROW = 20;
   localparam int CNT_W_WIDE = 27;
   localparam int MAX_LOW_W = 4;
   localparam int SEED_W = 7;
   localparam int LAT_W = 16;
   localparam int SLOTS = 4;
   // ==========================================================
   // Model-specific register selectors
   localparam logic [2:0] SEL_CTL = 3'h0;
   localparam logic [2:0] SEL_CUR = 3'h1;
   localparam logic [2:0] SEL_BRINFO = 3'h2;
   localparam logic [2:0] SEL_ADDR = 3'h3;
   localparam logic [2:0] SEL_MEMINFO = 3'h4;
   localparam logic [2:0] SEL_TARGET = 3'h5;
   // ==========================================================
   // Field positions
   localparam int CTL_EN_BIT = 32;
   localparam int CTL_MODE_BIT = 33;
   localparam int CTL_VALID_BIT = 34;
   localparam int BI_C2R_LSB = 16;
   localparam int BI_BRANCH_BIT = 32;
   localparam int BI_MISP_BIT = 33;
   localparam int BI_TAKEN_BIT = 34;
   localparam int BI_RETURN_BIT = 35;
   localparam int BI_RETMISP_BIT = 36;
   localparam int BI_RESYNC_BIT = 37;
   localparam int BI_ADDRINV_BIT = 38;
   localparam int MI_LOAD_BIT = 0;
   localparam int MI_STORE_BIT = 1;
   // ==========================================================
   // LFSR reset seed and taps, maximum and counter masks
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;
   localparam logic [22:0] MAX_HI_MASK_NARROW = 23'h00FFFF;
   localparam logic [22:0] MAX_HI_MASK_WIDE = 23'h7FFFFF;
   localparam logic [26:0] CNT_MASK_NARROW = 27'h00FFFFF;
   localparam logic [26:0] CNT_MASK_WIDE = 27'h7FFFFFF;
   // ==========================================================
   // Types
   typedef enum logic {MODE_CYCLES, MODE_DISPATCH} opsmp_mode_t;
   typedef enum logic [1:0] {S_COUNT, S_PEND, S_TRACK, S_DONE} opsmp_fsm_t;
   typedef struct packed {
      logic branch;
      logic misp;
      logic taken;
      logic is_return;
      logic ret_misp;
      logic resync;
      logic load;
      logic store;
      logic addr_invalid;
      logic [63:0] addr;
      logic [63:0] target;
   } opsmp_ret_t;
   typedef struct packed {
      opsmp_fsm_t fsm;
      logic en;
      opsmp_mode_t mode;
      logic [22:0] max_hi;
      logic [26:0] cnt;
      logic [1:0] rr;
      logic [15:0] lfsr;
      logic cmp;
      logic [15:0] t2r;
      logic [15:0] c2r;
      logic [15:0] t2r_cap;
      logic [15:0] c2r_cap;
      opsmp_ret_t smp;
      logic irq;
      logic drop;
      logic tag_v;
      logic [1:0] tag_slot;
      logic [63:0] rdata;
   } opsmp_state_t;
endpackage

//--- logic/opsmp_unit.sv
// Op sampling unit: tags one op, times it to retirement and holds the sample.
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Narrow variant: 20-bit counter and maximum, upper 16 maximum bits writable.
// (R2) Wide variant: 27-bit counter and maximum, upper 23 maximum bits writable.
// (R3) Lowest four maximum bits always read and act as zero.
// (R4) Software reads and writes the current selection counter.
// (R5) Control register mode bit chooses cycle or dispatched-op tagging.
// (R6) Cycle mode: count cycles, round-robin slot in next line, else younger.
// (R7) Dispatch mode: count dispatched ops, tag the op that reaches maximum.
// (R8) Retirement of the tagged op raises the interrupt with sample readable.
// (R9) Flushed tagged op: drop sample, no interrupt, pulse dropped-sample event.
// (R10) After flush load counter with 7-bit pseudo-random value and resume.
// (R11) Software seeds the counter randomly, mainly its lowest four bits.
// (R12) Tag at decode exit and count every cycle until retirement.
// (R13) Count cycles from execution completion to retirement separately.
// (R14) Report parent instruction address and both counts for every sample.
// (R15) Retired-branch flag set only for architectural branch ops.
// (R16) Mispredict and taken flags reported independently for branch ops.
// (R17) Return flag for returns; return-mispredict only meaningful with it.
// (R18) Resync ops flagged, never predicted, always taken.
// (R19) Load and store flags reported as the op performed them.
// (R20) No type flag set means undifferentiated op, address and counts valid.
// (R21) Wide variant only: instruction-address-invalid flag.
// (R22) Wide variant only: branch target register, zero means not valid.
// (R23) One op tagged at a time; sample held until software re-arms.
module opsmp_unit
   import opsmp_pkg::*;
#(
   parameter int P_WIDE = 0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Register access
   input wire logic i_msr_rd,
   input wire logic i_msr_wr,
   input wire logic [2:0] i_msr_sel,
   input wire logic [63:0] i_msr_wdata,
   output logic [63:0] o_msr_rdata,
   // Dispatch line
   input wire logic i_disp_fire,
   input wire logic [SLOTS-1:0] i_disp_slot_v,
   output logic o_tag_valid,
   output logic [1:0] o_tag_slot,
   // Tagged op progress
   input wire logic i_tag_complete,
   input wire logic i_tag_retire,
   input wire logic i_tag_flush,
   input wire opsmp_ret_t i_ret_info,
   // Events
   output logic o_irq,
   output logic o_drop
);
   // ==========================================================
   // Variant selection
   localparam logic [26:0] CNT_MASK =
      (P_WIDE != 0) ? CNT_MASK_WIDE : CNT_MASK_NARROW; // [R1] [R2]
   localparam logic [22:0] HI_MASK = (P_WIDE != 0) ? MAX_HI_MASK_WIDE : MAX_HI_MASK_NARROW;
   localparam logic [26:0] SEED_MASK = 27'h000007F;

   if (P_WIDE != 0 && P_WIDE != 1) begin : g_bad_variant
      $error("P_WIDE must be 0 or 1");
   end

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   opsmp_state_t r;
   opsmp_state_t n;
   logic [26:0] mx;
   logic [26:0] c;
   logic hit;
   logic [2:0] idx;
   logic [63:0] rd;

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      c = 27'h0;
      hit = 1'b0;
      idx = 3'h0;
      rd = 64'h0;
      n.tag_v = 1'b0;
      n.drop = 1'b0;
      n.lfsr = {1'b0, r.lfsr[15:1]} ^ (r.lfsr[0] ? LFSR_TAPS : 16'h0000);
      mx = {r.max_hi[22:0], 4'h0} & CNT_MASK; // [R3]
      case (r.fsm)
         S_COUNT: begin
            if (r.en && r.mode == MODE_CYCLES) begin
               n.cnt = (r.cnt + 27'h1) & CNT_MASK; // [R6]
               if (n.cnt >= mx) begin
                  n.cnt = 27'h0;
                  n.fsm = S_PEND;
               end
            end else if (r.en && i_disp_fire) begin
               // Ops are counted oldest first, so at most one hits per line.
               c = r.cnt;
               for (int i = 0; i < SLOTS; i++) begin
                  if (i_disp_slot_v[i] && !hit) begin
                     c = (c + 27'h1) & CNT_MASK; // [R7]
                     if (c >= mx) begin
                        hit = 1'b1;
                        c = 27'h0;
                        n.tag_slot = 2'(i);
                     end
                  end
               end
               n.cnt = c;
               if (hit) begin
                  n.tag_v = 1'b1;
               end
            end
         end
         S_PEND: begin
            if (!r.en) begin
               n.fsm = S_COUNT;
            end else if (i_disp_fire) begin
               // Only the round-robin slot and younger slots of the same line are tried; else the next line.
               for (int k = 0; k < SLOTS; k++) begin
                  idx = {1'b0, r.rr} + 3'(k);
                  if (!hit && idx < 3'(SLOTS) && i_disp_slot_v[idx[1:0]]) begin
                     hit = 1'b1; // [R6]
                     n.tag_slot = idx[1:0];
                  end
               end
               if (hit) begin
                  n.tag_v = 1'b1;
                  n.rr = r.rr + 2'h1;
               end
            end
         end
         S_TRACK: begin
            n.t2r = sat_inc(r.t2r); // [R12]
            if (r.cmp) begin
               n.c2r = sat_inc(r.c2r); // [R13]
            end
            if (i_tag_complete) begin
               n.cmp = 1'b1;
            end
            if (i_tag_flush) begin
               n.drop = 1'b1; // [R9]
               n.cnt = {20'h0, r.lfsr[SEED_W-1:0]} & SEED_MASK; // [R10]
               n.fsm = S_COUNT;
            end else if (i_tag_retire) begin
               n.t2r_cap = sat_inc(r.t2r); // [R14]
               n.c2r_cap = r.cmp ? sat_inc(r.c2r) : 16'h0000;
               n.smp.addr = i_ret_info.addr;
               n.smp.branch = i_ret_info.branch; // [R15]
               n.smp.resync = i_ret_info.resync;
               n.smp.misp = (i_ret_info.branch && i_ret_info.misp)
                  && !i_ret_info.resync; // [R16] [R18]
               n.smp.taken = (i_ret_info.branch && i_ret_info.taken) || i_ret_info.resync;
               n.smp.is_return = i_ret_info.is_return; // [R17]
               n.smp.ret_misp = i_ret_info.is_return && i_ret_info.ret_misp;
               n.smp.load = i_ret_info.load; // [R19]
               n.smp.store = i_ret_info.store;
               n.smp.addr_invalid = (P_WIDE != 0) && i_ret_info.addr_invalid; // [R21]
               n.smp.target = ((P_WIDE != 0) && i_ret_info.branch)
                  ? i_ret_info.target : 64'h0; // [R22]
               n.irq = 1'b1; // [R8]
               n.fsm = S_DONE;
            end
         end
         S_DONE: begin
            n.fsm = S_DONE; // [R23]
         end
         default: begin
            n.fsm = S_COUNT;
         end
      endcase
      if (n.tag_v) begin
         n.fsm = S_TRACK;
         n.t2r = 16'h0000;
         n.c2r = 16'h0000;
         n.cmp = 1'b0;
      end
      if (i_msr_wr && i_msr_sel == SEL_CTL) begin
         n.en = i_msr_wdata[CTL_EN_BIT];
         n.mode = opsmp_mode_t'(i_msr_wdata[CTL_MODE_BIT]); // [R5]
         n.max_hi = i_msr_wdata[26:MAX_LOW_W] & HI_MASK; // [R1] [R2]
         // Clearing the valid bit only takes effect once a sample is held.
         if (!i_msr_wdata[CTL_VALID_BIT] && r.fsm == S_DONE) begin
            n.irq = 1'b0; // [R23]
            n.fsm = S_COUNT;
         end
      end
      if (i_msr_wr && i_msr_sel == SEL_CUR) begin
         n.cnt = i_msr_wdata[26:0] & CNT_MASK; // [R4] [R11]
      end
      if (i_msr_rd) begin
         case (i_msr_sel)
            SEL_CTL: begin
               rd[26:MAX_LOW_W] = r.max_hi; // [R3]
               rd[CTL_EN_BIT] = r.en;
               rd[CTL_MODE_BIT] = r.mode;
               rd[CTL_VALID_BIT] = r.irq;
            end
            SEL_CUR: begin
               rd[26:0] = r.cnt; // [R4]
            end
            SEL_BRINFO: begin
               rd[LAT_W-1:0] = r.t2r_cap;
               rd[BI_C2R_LSB+LAT_W-1:BI_C2R_LSB] = r.c2r_cap;
               rd[BI_BRANCH_BIT] = r.smp.branch;
               rd[BI_MISP_BIT] = r.smp.misp;
               rd[BI_TAKEN_BIT] = r.smp.taken;
               rd[BI_RETURN_BIT] = r.smp.is_return;
               rd[BI_RETMISP_BIT] = r.smp.ret_misp;
               rd[BI_RESYNC_BIT] = r.smp.resync; // [R20]
               rd[BI_ADDRINV_BIT] = r.smp.addr_invalid;
            end
            SEL_ADDR: begin
               rd = r.smp.addr; // [R14]
            end
            SEL_MEMINFO: begin
               rd[MI_LOAD_BIT] = r.smp.load;
               rd[MI_STORE_BIT] = r.smp.store;
            end
            SEL_TARGET: begin
               rd = r.smp.target;
            end
            default: begin
               rd = 64'h0;
            end
         endcase
         n.rdata = rd;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r <= '0;
         r.lfsr <= LFSR_SEED;
      end else begin
         r <= n;
      end
   end

   assign o_msr_rdata = r.rdata;
   assign o_tag_valid = r.tag_v;
   assign o_tag_slot = r.tag_slot;
   assign o_irq = r.irq;
   assign o_drop = r.drop;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_flush_taken;
      r.fsm == S_TRACK && i_tag_flush;
   endsequence
   sequence s_retire_taken;
      r.fsm == S_TRACK && i_tag_retire && !i_tag_flush;
   endsequence

   ctl_low_zero_a: assert property ( // [R3]
      $past(i_msr_rd) && $past(i_msr_sel) == SEL_CTL |-> o_msr_rdata[3:0] == 4'h0
   ) else $error("max low bits not zero");
   narrow_width_a: assert property ( // [R1]
      P_WIDE == 0 |-> r.cnt[26:20] == 7'h00
   ) else $error("narrow counter overflow");
   flush_drop_a: assert property ( // [R9]
      s_flush_taken |=> o_drop && !o_irq && r.fsm == S_COUNT
   ) else $error("flush not dropped");
   flush_seed_a: assert property ( // [R10]
      (s_flush_taken and !i_msr_wr) |=> r.cnt <= 27'h000007F
   ) else $error("bad reseed");
   retire_irq_a: assert property ( // [R8]
      s_retire_taken |=> o_irq ##1 o_irq
   ) else $error("no interrupt");
   single_tag_a: assert property ( // [R23]
      o_tag_valid |-> r.fsm == S_TRACK ##1 !o_tag_valid
   ) else $error("double tag");
   resync_taken_a: assert property ( // [R18]
      (s_retire_taken and i_ret_info.resync) |=> r.smp.taken && !r.smp.misp
   ) else $error("resync flags");
   ret_misp_a: assert property ( // [R17]
      !r.smp.is_return |-> !r.smp.ret_misp
   ) else $error("return mispredict without return");
   cycle_step_a: assert property ( // [R6]
      r.fsm == S_COUNT && r.en && r.mode == MODE_CYCLES && !i_msr_wr && r.cnt + 27'h2 < mx
      |=> r.cnt == $past(r.cnt) + 27'h1
   ) else $error("cycle count stuck");
   t2r_step_a: assert property ( // [R12]
      r.fsm == S_TRACK && !i_tag_retire && !i_tag_flush && r.t2r < 16'h00FF
      |=> r.t2r == $past(r.t2r) + 16'h0001
   ) else $error("tag latency stuck");
   sample_hold_a: assert property ( // [R23]
      r.fsm == S_DONE && !(i_msr_wr && i_msr_sel == SEL_CTL) |=> r.fsm == S_DONE && $stable(r.smp)
   ) else $error("held sample changed");
   irq_held_a: assert property ( // [R8]
      o_irq |-> r.fsm == S_DONE
   ) else $error("interrupt without sample");
   tag_on_fire_a: assert property ( // [R7]
      o_tag_valid |-> $past(i_disp_fire) && $past(i_disp_slot_v) != 4'h0
   ) else $error("tag without dispatch");
   c2r_wait_a: assert property ( // [R13]
      r.fsm == S_TRACK && !r.cmp |=> r.c2r == 16'h0000
   ) else $error("completion count early");
   narrow_flags_a: assert property ( // [R21]
      P_WIDE == 0 |-> !r.smp.addr_invalid && r.smp.target == 64'h0
   ) else $error("wide-only field set");
endmodule
`default_nettype wire

//--- test/opsmp_core_model.sv
// Core pipeline model that completes, retires or flushes the tagged op.
`timescale 1ns/1ps
`default_nettype none
module opsmp_core_model
   import opsmp_pkg::*;
(
   // Clock and tag
   input wire logic i_clk,
   input wire logic i_tag_valid,
   // Commands from the bench
   input wire logic [3:0] i_c_dly,
   input wire logic [3:0] i_r_dly,
   input wire logic i_do_flush,
   input wire opsmp_ret_t i_info,
   // Progress of the tagged op
   output logic o_complete,
   output logic o_retire,
   output logic o_flush,
   output opsmp_ret_t o_ret_info
);
   // ==========================================================
   // Retire info
   // Outside the retire cycle the lines carry the inverse, so a stale copy never matches.
   assign o_ret_info = o_retire ? i_info : opsmp_ret_t'(~i_info);
   // ==========================================================
   // Progress sequence
   // Delays count from the tag cycle; completion always comes before the final event.
   initial begin
      o_complete = 1'b0;
      o_retire = 1'b0;
      o_flush = 1'b0;
      forever begin
         @(negedge i_clk);
         if (i_tag_valid) begin
            repeat (i_c_dly) @(negedge i_clk);
            o_complete = 1'b1;
            @(negedge i_clk);
            o_complete = 1'b0;
            repeat (i_r_dly - i_c_dly - 4'h1) @(negedge i_clk);
            o_retire = !i_do_flush;
            o_flush = i_do_flush;
            @(negedge i_clk);
            o_retire = 1'b0;
            o_flush = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/op_sampling_unit_tb_top.sv
// Testbench for the op sampling unit: registers, tagging, retire and flush.
`timescale 1ns/1ps
`default_nettype none
module op_sampling_unit_tb_top;
   import opsmp_pkg::*;
   localparam logic [63:0] ALL = 64'hFFFFFFFFFFFFFFFF;
   logic clk, rstn, rd, wr, fire, tv, cpl, ret, fl, irq, drop, dfl, rd_s;
   logic [2:0] sel;
   logic [63:0] wdata, rdata, e;
   logic [3:0] slot_v, cd, rdl;
   logic [1:0] tslot;
   opsmp_ret_t info, rinfo;
   logic [63:0] q_rd[$];
   logic [1:0] q_tag[$];
   int n_mismatch, n_tests, cyc;
   opsmp_unit #(.P_WIDE(0)) u_opsmp_unit (.i_clk(clk), .i_rstn(rstn), .i_msr_rd(rd),
      .i_msr_wr(wr), .i_msr_sel(sel), .i_msr_wdata(wdata), .o_msr_rdata(rdata),
      .i_disp_fire(fire), .i_disp_slot_v(slot_v), .o_tag_valid(tv), .o_tag_slot(tslot),
      .i_tag_complete(cpl), .i_tag_retire(ret), .i_tag_flush(fl), .i_ret_info(rinfo),
      .o_irq(irq), .o_drop(drop));
   opsmp_core_model u_opsmp_core_model (.i_clk(clk), .i_tag_valid(tv), .i_c_dly(cd),
      .i_r_dly(rdl), .i_do_flush(dfl), .i_info(info), .o_complete(cpl), .o_retire(ret),
      .o_flush(fl), .o_ret_info(rinfo));
   // ==========================================================
   // Clock, timeout and report
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp_rd(input logic [63:0] x, input logic [63:0] a);
      n_tests++;
      if (a !== x) begin
         n_mismatch++;
         $display("[ERR] %0t read got %h expected %h", $time, a, x);
      end
   endtask
   task automatic cmp_ev(input logic [1:0] x, input logic [1:0] a);
      n_tests++;
      if (a !== x) begin
         n_mismatch++;
         $display("[ERR] %0t event got %h expected %h", $time, a, x);
      end
   endtask
   // ==========================================================
   // Monitor
   // Read data is taken one cycle after the strobe; an unexpected tag finds an empty queue.
   always @(posedge clk) rd_s <= rd;
   always @(negedge clk) begin : mon
      logic [63:0] xv;
      logic [63:0] mv;
      if (rd_s) begin
         xv = q_rd.pop_front();
         mv = q_rd.pop_front();
         cmp_rd(xv, rdata & mv);
      end
      if (tv) begin
         if (q_tag.size() == 0) begin
            cmp_ev(2'h0, {1'b0, tv});
         end else begin
            cmp_ev(q_tag.pop_front(), tslot);
         end
      end
   end
   // ==========================================================
   // Drivers
   task automatic wreg(input logic [2:0] s, input logic [63:0] d);
      @(negedge clk);
      wr = 1'b1;
      sel = s;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rreg(input logic [2:0] s, input logic [63:0] x, input logic [63:0] m);
      @(negedge clk);
      rd = 1'b1;
      sel = s;
      q_rd.push_back(x & m);
      q_rd.push_back(m);
      @(negedge clk);
      rd = 1'b0;
   endtask
   task automatic line(input logic [3:0] v);
      @(negedge clk);
      fire = 1'b1;
      slot_v = v;
      @(negedge clk);
      fire = 1'b0;
      slot_v = ~v;
   endtask
   task automatic waitsig(ref logic s);
      for (int k = 0; k < 40 && s !== 1'b1; k++) @(negedge clk);
   endtask
   function automatic logic [63:0] ctl(input logic en, input logic md, input logic [26:0] mx);
      ctl = {37'h0, mx};
      ctl[CTL_EN_BIT] = en;
      ctl[CTL_MODE_BIT] = md;
   endfunction
   // Re-arming also presets the counter, so the tag position is known.
   task automatic arm(input logic md, input logic [3:0] c, input logic [3:0] r);
      cd = c;
      rdl = r;
      wreg(SEL_CUR, 64'h0);
      wreg(SEL_CTL, ctl(1'b1, md, 27'h0000010));
      cmp_ev(2'h0, {1'b0, irq});
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      rstn = 1'b0;
      {rd, wr, fire, dfl} = 4'h0;
      sel = 3'h0;
      wdata = 64'h0;
      slot_v = 4'h0;
      {cd, rdl} = 8'h25;
      info = '0;
      void'($urandom(67));
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      rreg(SEL_CTL, 64'h0, ALL);
      rreg(SEL_CUR, 64'h0, ALL);
      e = {$urandom, $urandom};
      wreg(SEL_CTL, ctl(1'b0, 1'b1, e[26:0]));
      rreg(SEL_CTL, ctl(1'b0, 1'b1, e[26:0] & 27'h00FFFF0), ALL);
      wreg(SEL_CUR, e);
      rreg(SEL_CUR, e, {37'h0, CNT_MASK_NARROW});
      rreg(3'h6, 64'h0, ALL);
      {info.branch, info.is_return, info.addr_invalid} = 3'h7;
      {info.ret_misp, info.taken, info.misp, info.store, info.load} = e[4:0];
      info.addr = e;
      info.target = ~e;
      arm(1'b0, 4'h2, 4'h5);
      repeat (25) @(negedge clk);
      q_tag.push_back(2'h2);
      line(4'hC);
      waitsig(irq);
      cmp_ev(2'h1, {1'b0, irq});
      rreg(SEL_BRINFO, {25'h0, 2'h0, e[4], 1'b1, e[3], e[2], 1'b1, 32'h00030006},
         ALL);
      rreg(SEL_ADDR, e, ALL);
      rreg(SEL_MEMINFO, {62'h0, e[1:0]}, 64'h3);
      rreg(SEL_TARGET, 64'h0, ALL);
      wreg(SEL_BRINFO, 64'h0);
      line(4'hF);
      rreg(SEL_CTL, ALL, 64'h1 << CTL_VALID_BIT);
      rreg(SEL_BRINFO, {25'h0, 2'h0, e[4], 1'b1, e[3], e[2], 1'b1, 32'h00030006}, ALL);
      info = '0;
      {info.resync, info.misp, info.load, info.store} = 4'hF;
      info.addr = ~e;
      arm(1'b1, 4'h1, 4'h4);
      q_tag.push_back(2'h3);
      repeat (4) line(4'hF);
      waitsig(irq);
      cmp_ev(2'h1, {1'b0, irq});
      rreg(SEL_BRINFO, {25'h0, 7'h24, 32'h00030005}, ALL);
      rreg(SEL_MEMINFO, 64'h3, 64'h3);
      rreg(SEL_ADDR, ~e, ALL);
      dfl = 1'b1;
      arm(1'b1, 4'h0, 4'h3);
      q_tag.push_back(2'h3);
      repeat (4) line(4'hF);
      waitsig(drop);
      cmp_ev(2'h1, {1'b0, drop});
      cmp_ev(2'h0, {1'b0, irq});
      rreg(SEL_CUR, 64'h0, ~64'h7F);
      // An op with no type flag still reports its address and both counts.
      dfl = 1'b0;
      info = '0;
      info.addr = {e[31:0], e[63:32]};
      arm(1'b1, 4'h3, 4'h7);
      q_tag.push_back(2'h3);
      repeat (4) line(4'hF);
      waitsig(irq);
      cmp_ev(2'h1, {1'b0, irq});
      rreg(SEL_BRINFO, {32'h0, 32'h00040008}, ALL);
      rreg(SEL_ADDR, {e[31:0], e[63:32]}, ALL);
      rreg(SEL_MEMINFO, 64'h0, 64'h3);
      repeat (5) @(negedge clk);
      cmp_ev(2'h0, {1'b0, q_tag.size() != 0 || q_rd.size() != 0});
      final_report();
   end
endmodule
`default_nettype wire
